//--- dac_serial_pkg.sv
// Shared constants and carriers for the DAC serial input front end.
// Assumes a 200 MHz system clock and a host serial clock of at most 30 MHz.
package dac_serial_pkg;

    // Frame layout: address byte on top, data word below, sent MSB first
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int SYNC_STAGES = 2;

    // Address byte decode
    localparam logic [7:0] ADDR_NOP = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h01;
    localparam logic [7:0] ADDR_READBACK = 8'h02;
    localparam logic [7:0] ADDR_CONTROL = 8'h55;
    localparam logic [7:0] ADDR_RESET = 8'h56;

    // Control word fields
    localparam int CTRL_RANGE_LSB = 0;
    localparam int CTRL_RANGE_W = 3;
    localparam int CTRL_OVERRANGE_BIT = 3;
    localparam int CTRL_TWOS_BIT = 4;
    localparam int CTRL_ENABLE_BIT = 12;
    // Reset command and readback select fields
    localparam int RESET_CMD_BIT = 0;
    localparam int READ_SEL_LSB = 0;
    localparam int READ_SEL_W = 2;

    // Output range codes held in the control word
    localparam logic [2:0] RANGE_V_0_5 = 3'h0;
    localparam logic [2:0] RANGE_V_0_10 = 3'h1;
    localparam logic [2:0] RANGE_V_PM5 = 3'h2;
    localparam logic [2:0] RANGE_V_PM10 = 3'h3;
    localparam logic [2:0] RANGE_I_4_20 = 3'h5;
    localparam logic [2:0] RANGE_I_0_20 = 3'h6;
    localparam logic [2:0] RANGE_I_0_24 = 3'h7;

    // Values after reset
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [1:0] READ_SEL_RESET = 2'h0;

    // Serial clock limit against the system clock
    localparam int SCLK_MAX_KHZ = 30000;
    localparam int SYS_CLK_KHZ = 200000;
    localparam int SCLK_MIN_PERIOD_NS = (1000000 + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
    localparam int SYS_PERIOD_NS = 1000000 / SYS_CLK_KHZ;
    localparam int SCLK_MIN_PERIOD_CYC =
        (SCLK_MIN_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } frame_s;

    typedef struct packed {
        logic current_on;
        logic voltage_on;
        logic [CTRL_RANGE_W-1:0] range;
        logic overrange;
    } drive_s;

    typedef enum {ST_IDLE, ST_APPLY, ST_CONVERT} apply_e;

endpackage

//--- dac_serial_input.sv
// DAC serial input front end: shift register, latch capture, register routing
// and conversion of the DAC code into segment and ladder switch controls.
// Assumes the host stops or holds the serial word still around the latch rise.
`timescale 1ns/1ps
// What this block does
// R1: Serial clock up to 30 MHz works.
// R2: Shift register is exactly 24 bits.
// R3: MSB first, sampled on serial clock rise.
// R4: Word is address byte then 16 data.
// R5: Every latch rise captures the shift register.
// R6: Shifting continues whatever the latch level.
// R7: Captured word is last 24 bits shifted.
// R8: Current or voltage output, never both.
// R9: Three current and four voltage ranges, overrange.
// R10: Top four code bits drive fifteen segments.
// R11: Lower code bits drive ladder switches directly.
// R12: Host disables output before voltage range change.
// R13: Negative full scale at 0x0000 or 0x8000.
// R14: Host gives exactly 24 edges per latch.
// R15: Address byte decode: nop, data, readback, control, reset.
// R16: Latched data goes to addressed register.
module dac_serial_input #(
    parameter int RES_BITS = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic sdin_in,
    input wire logic latch_in,
    output logic current_enable_out,
    output logic voltage_enable_out,
    output logic [2:0] range_out,
    output logic overrange_out,
    output logic [14:0] segment_switches_out,
    output logic [RES_BITS-5:0] ladder_switches_out,
    output logic [1:0] readback_select_out,
    output logic readback_request_out,
    output logic [23:0] latched_word_out
);

    localparam int LADDER_W = RES_BITS - 4;
    localparam int SEG_W = 15;

    // Serial clock domain

    logic [dac_serial_pkg::FRAME_BITS-1:0] shift;
    logic [dac_serial_pkg::FRAME_BITS-1:0] next_shift;

    // No reset here: the serial clock may stand still during reset, and a
    // frame of 24 edges refills every bit anyway.
    always_comb begin
        next_shift = {shift[dac_serial_pkg::FRAME_BITS-2:0], sdin_in}; // R3 R4
    end

    always_ff @(posedge sclk_in) begin
        shift <= next_shift; // R2 R6
    end

    // System clock domain: crossing

    // The word is quiet once the host has stopped shifting, so a two-stage
    // copy settles before the equally delayed latch edge is seen. At 30 MHz
    // the serial period spans several system cycles, which this relies on.
    logic [dac_serial_pkg::FRAME_BITS-1:0] word_meta;
    logic [dac_serial_pkg::FRAME_BITS-1:0] word_sync;
    logic [dac_serial_pkg::FRAME_BITS-1:0] next_word_meta;
    logic [dac_serial_pkg::FRAME_BITS-1:0] next_word_sync;
    logic latch_meta;
    logic latch_sync;
    logic latch_prev;
    logic latch_rise;
    logic next_latch_meta;
    logic next_latch_sync;
    logic next_latch_prev;

    // Word and latch take the same two stages, so neither outruns the other
    always_comb begin
        next_word_meta = shift; // R1
        next_word_sync = word_meta;
        next_latch_meta = latch_in;
        next_latch_sync = latch_meta;
        next_latch_prev = latch_sync;
    end

    always_ff @(posedge sys_clk_in) begin
        word_meta <= next_word_meta;
        word_sync <= next_word_sync;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            latch_meta <= 1'b0;
            latch_sync <= 1'b0;
            latch_prev <= 1'b0;
        end else begin
            latch_meta <= next_latch_meta;
            latch_sync <= next_latch_sync;
            latch_prev <= next_latch_prev;
        end
    end

    always_comb begin
        latch_rise = latch_sync && !latch_prev;
    end

    // Capture, routing and conversion

    dac_serial_pkg::apply_e state;
    dac_serial_pkg::apply_e next_state;
    dac_serial_pkg::frame_s frame;
    dac_serial_pkg::frame_s next_frame;
    logic [15:0] control;
    logic [15:0] next_control;
    logic [15:0] dac_code;
    logic [15:0] next_dac_code;
    logic [1:0] read_sel;
    logic [1:0] next_read_sel;
    logic read_req;
    logic next_read_req;

    // A latch rise always wins, even mid-apply, so no capture is lost;
    // the apply of the older frame is dropped then
    always_comb begin
        next_state = state;
        next_frame = frame;
        if (latch_rise) begin
            next_frame = dac_serial_pkg::frame_s'(word_sync); // R5 R7
            next_state = dac_serial_pkg::ST_APPLY;
        end else begin
            case (state)
                dac_serial_pkg::ST_APPLY: begin
                    next_state = dac_serial_pkg::ST_CONVERT;
                end
                dac_serial_pkg::ST_CONVERT: begin
                    next_state = dac_serial_pkg::ST_IDLE;
                end
                default: begin
                    next_state = dac_serial_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state <= dac_serial_pkg::ST_IDLE;
            frame <= '0;
        end else begin
            state <= next_state;
            frame <= next_frame;
        end
    end

    // Writes land one cycle after capture, the switch outputs one later
    always_comb begin
        next_control = control;
        next_dac_code = dac_code;
        next_read_sel = read_sel;
        next_read_req = read_req;
        if (!latch_rise && state == dac_serial_pkg::ST_APPLY) begin
            next_read_req = 1'b0;
            if (frame.addr == dac_serial_pkg::ADDR_DATA) begin // R15
                next_dac_code = frame.data; // R16
            end else if (frame.addr == dac_serial_pkg::ADDR_CONTROL) begin
                next_control = frame.data; // R16
            end else if (frame.addr == dac_serial_pkg::ADDR_READBACK) begin
                next_read_sel = frame.data[dac_serial_pkg::READ_SEL_LSB +:
                    dac_serial_pkg::READ_SEL_W];
                next_read_req = 1'b1;
            end else if (frame.addr == dac_serial_pkg::ADDR_RESET) begin
                if (frame.data[dac_serial_pkg::RESET_CMD_BIT]) begin
                    next_control = dac_serial_pkg::CONTROL_RESET;
                    next_dac_code = dac_serial_pkg::DATA_RESET;
                    next_read_sel = dac_serial_pkg::READ_SEL_RESET;
                end
            end else begin
                // No-operation and unknown addresses touch nothing but the readback request, which every apply except a readback clears
                next_control = control; // R16
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            control <= dac_serial_pkg::CONTROL_RESET;
            dac_code <= dac_serial_pkg::DATA_RESET;
            read_sel <= dac_serial_pkg::READ_SEL_RESET;
            read_req <= 1'b0;
        end else begin
            control <= next_control;
            dac_code <= next_dac_code;
            read_sel <= next_read_sel;
            read_req <= next_read_req;
        end
    end

    function automatic logic range_is_current(input logic [2:0] code);
        case (code)
            dac_serial_pkg::RANGE_I_4_20, dac_serial_pkg::RANGE_I_0_20,
            dac_serial_pkg::RANGE_I_0_24: begin
                range_is_current = 1'b1;
            end
            default: begin
                range_is_current = 1'b0;
            end
        endcase
    endfunction

    function automatic logic range_is_voltage(input logic [2:0] code);
        case (code)
            dac_serial_pkg::RANGE_V_0_5, dac_serial_pkg::RANGE_V_0_10,
            dac_serial_pkg::RANGE_V_PM5, dac_serial_pkg::RANGE_V_PM10: begin
                range_is_voltage = 1'b1;
            end
            default: begin
                range_is_voltage = 1'b0;
            end
        endcase
    endfunction

    logic [2:0] ctrl_range;
    logic ctrl_enable;
    logic ctrl_twos;
    logic [15:0] offset_code;
    logic [3:0] top_code;
    dac_serial_pkg::drive_s next_drive;
    logic [SEG_W-1:0] next_segments;
    logic [LADDER_W-1:0] next_ladder;

    always_comb begin
        ctrl_range = control[dac_serial_pkg::CTRL_RANGE_LSB +: dac_serial_pkg::CTRL_RANGE_W];
        ctrl_enable = control[dac_serial_pkg::CTRL_ENABLE_BIT];
        ctrl_twos = control[dac_serial_pkg::CTRL_TWOS_BIT];
        // Flipping the sign bit turns 0x8000 into the bottom of the ladder
        offset_code = ctrl_twos ? {~dac_code[15], dac_code[14:0]} : dac_code; // R13
        top_code = offset_code[15:12];
        next_ladder = offset_code[11 -: LADDER_W]; // R11
        // Reserved range code 4 drives neither output
        next_drive.current_on = ctrl_enable && range_is_current(ctrl_range); // R8 R9
        next_drive.voltage_on = ctrl_enable && range_is_voltage(ctrl_range); // R8 R9
        next_drive.range = ctrl_range; // R9
        next_drive.overrange = control[dac_serial_pkg::CTRL_OVERRANGE_BIT] &&
            range_is_voltage(ctrl_range); // R9
    end

    // Thermometer decode: segment i closes to the reference when the top
    // code exceeds i, so all fifteen resistors are matched in weight.
    genvar seg;
    generate
        for (seg = 0; seg < SEG_W; seg = seg + 1) begin : g_seg
            always_comb begin
                next_segments[seg] = (top_code > 4'(seg)); // R10
            end
        end
    endgenerate

    logic next_current_enable;
    logic next_voltage_enable;
    logic [2:0] next_range;
    logic next_overrange;
    logic [SEG_W-1:0] next_segment_switches;
    logic [LADDER_W-1:0] next_ladder_switches;
    logic [1:0] next_readback_select;
    logic next_readback_request;
    logic [23:0] next_latched_word;

    // Every output leaves a flip-flop, so the switches never see a decode glitch
    always_comb begin
        next_current_enable = next_drive.current_on; // R8
        next_voltage_enable = next_drive.voltage_on; // R8
        next_range = next_drive.range;
        next_overrange = next_drive.overrange;
        next_segment_switches = next_segments;
        next_ladder_switches = next_ladder;
        next_readback_select = read_sel;
        next_readback_request = read_req;
        next_latched_word = frame;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            current_enable_out <= 1'b0;
            voltage_enable_out <= 1'b0;
            range_out <= 3'h0;
            overrange_out <= 1'b0;
            segment_switches_out <= '0;
            ladder_switches_out <= '0;
            readback_select_out <= dac_serial_pkg::READ_SEL_RESET;
            readback_request_out <= 1'b0;
            latched_word_out <= '0;
        end else begin
            current_enable_out <= next_current_enable;
            voltage_enable_out <= next_voltage_enable;
            range_out <= next_range;
            overrange_out <= next_overrange;
            segment_switches_out <= next_segment_switches;
            ladder_switches_out <= next_ladder_switches;
            readback_select_out <= next_readback_select;
            readback_request_out <= next_readback_request;
            latched_word_out <= next_latched_word;
        end
    end

endmodule

//--- dac_serial_input_props.sv
// Concurrent checks on the ports of the DAC serial input front end.
// Assumes the latch pin moves only at frame ends, rises well apart.
`timescale 1ns/1ps
module dac_serial_input_props #(
    parameter int RES_BITS = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic sdin_in,
    input wire logic latch_in,
    input wire logic current_enable_out,
    input wire logic voltage_enable_out,
    input wire logic [2:0] range_out,
    input wire logic overrange_out,
    input wire logic [14:0] segment_switches_out,
    input wire logic [RES_BITS-5:0] ladder_switches_out,
    input wire logic [1:0] readback_select_out,
    input wire logic readback_request_out,
    input wire logic [23:0] latched_word_out
);
    logic latch_q;
    logic [4:0] since_latch;
    logic [4:0] next_since_latch;
    // Raw pin is seen two stages ahead of the design's synchroniser, so the quiet window
    // leaves room for sync plus the three-stage apply path
    always_comb begin
        next_since_latch = since_latch;
        if (latch_in && !latch_q) begin
            next_since_latch = 5'h00;
        end else if (since_latch != 5'h1f) begin
            next_since_latch = since_latch + 5'h01;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        latch_q <= latch_in;
        since_latch <= rst_in ? 5'h1f : next_since_latch;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    AST_ONE_OUTPUT: assert property (!(current_enable_out && voltage_enable_out))
        else $error("both outputs active");
    AST_THERMO: assert property (
        ((segment_switches_out + 15'h0001) & segment_switches_out) == 15'h0000)
        else $error("segments not a thermometer");
    AST_CUR_RANGE: assert property (current_enable_out |-> range_out[2])
        else $error("current output on a voltage range");
    AST_OVR_RANGE: assert property (overrange_out |-> !range_out[2])
        else $error("overrange on a current range");
    AST_RESET_CLEAR: assert property ($fell(rst_in) |->
        !current_enable_out && !voltage_enable_out && latched_word_out == 24'h000000 &&
        segment_switches_out == 15'h0000)
        else $error("outputs not cleared by reset");
    AST_WORD_QUIET: assert property (since_latch > 5'h0a |-> $stable(latched_word_out))
        else $error("word changed without latch");
    AST_DRIVE_QUIET: assert property (since_latch > 5'h0a |->
        $stable({range_out, segment_switches_out, readback_select_out}))
        else $error("outputs changed without latch");
    AST_RB_ADDR: assert property ($rose(readback_request_out) |->
        latched_word_out[23:16] == 8'h02)
        else $error("readback request without readback address");
    AST_LADDER: assert property ($changed(latched_word_out) &&
        latched_word_out[23:16] == 8'h01 |=>
        ladder_switches_out == $past(latched_word_out[11:0]))
        else $error("ladder not driven from code");
endmodule
bind dac_serial_input dac_serial_input_props #(.RES_BITS(RES_BITS)) u_props (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sclk_in(sclk_in),
    .sdin_in(sdin_in),
    .latch_in(latch_in),
    .current_enable_out(current_enable_out),
    .voltage_enable_out(voltage_enable_out),
    .range_out(range_out),
    .overrange_out(overrange_out),
    .segment_switches_out(segment_switches_out),
    .ladder_switches_out(ladder_switches_out),
    .readback_select_out(readback_select_out),
    .readback_request_out(readback_request_out),
    .latched_word_out(latched_word_out)
);

//--- dac_host_model.sv
// Host serial master model: shifts a word MSB first, then pulses the latch.
// Assumes the caller waits for each send to return before the next.
`timescale 1ns/1ps
module dac_host_model (
    output logic sclk_out,
    output logic sdin_out,
    output logic latch_out
);
    // Clock stands still low between frames; period kept just under the 30 MHz limit
    initial begin
        sclk_out = 1'b0;
        sdin_out = 1'b0;
        latch_out = 1'b0;
    end
    task automatic send(input logic [31:0] bits, input int n);
        #3.3;
        for (int i = n - 1; i >= 0; i--) begin
            sdin_out = bits[i];
            #17 sclk_out = 1'b1;
            #17 sclk_out = 1'b0;
        end
        // Line has no pull, so show the inverse once released
        sdin_out = ~sdin_out;
        #40 latch_out = 1'b1;
        #60 latch_out = 1'b0;
    endtask
endmodule

//--- dac_serial_input_test.sv
// Testbench for the DAC serial input front end with a model of the host.
// Assumes outputs settle within a few system cycles of the latch rise.
`timescale 1ns/1ps
module dac_serial_input_test;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sclk_in;
    logic sdin_in;
    logic latch_in;
    logic current_enable_out;
    logic voltage_enable_out;
    logic overrange_out;
    logic readback_request_out;
    logic [2:0] range_out;
    logic [14:0] segment_switches_out;
    logic [11:0] ladder_switches_out;
    logic [1:0] readback_select_out;
    logic [23:0] latched_word_out;
    logic [31:0] rng = 32'h00012d9d;
    logic [31:0] r;
    int num_errors = 0;
    int check_count = 0;
    int ctrl_m = 0;
    int code_m = 0;
    int rbsel_m = 0;
    int rbreq_m = 0;
    int sent_q[$];
    always #2.5 sys_clk_in = ~sys_clk_in;
    dac_host_model u_dac_host_model (.sclk_out(sclk_in), .sdin_out(sdin_in), .latch_out(latch_in));
    dac_serial_input u_dac_serial_input (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .sclk_in(sclk_in), .sdin_in(sdin_in), .latch_in(latch_in),
        .current_enable_out(current_enable_out), .voltage_enable_out(voltage_enable_out),
        .range_out(range_out), .overrange_out(overrange_out),
        .segment_switches_out(segment_switches_out), .ladder_switches_out(ladder_switches_out),
        .readback_select_out(readback_select_out), .readback_request_out(readback_request_out),
        .latched_word_out(latched_word_out));
    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic void apply(input int w);
        int a;
        int d;
        a = (w >> 16) & 255;
        d = w & 65535;
        rbreq_m = 0;
        if (a == 1) code_m = d;
        else if (a == 2) begin
            rbsel_m = d & 3;
            rbreq_m = 1;
        end else if (a == 'h55) ctrl_m = d;
        else if (a == 'h56 && (d & 1)) begin
            ctrl_m = 0;
            code_m = 0;
            rbsel_m = 0;
        end
    endfunction
    task automatic cmp(input logic [31:0] got, input int exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_all;
        int rc = ctrl_m & 7;
        int en = (ctrl_m >> 12) & 1;
        int c = ((ctrl_m >> 4) & 1) ? code_m ^ 'h8000 : code_m;
        cmp(current_enable_out, en && rc >= 5);
        cmp(voltage_enable_out, en && rc <= 3);
        cmp(range_out, rc);
        cmp(overrange_out, ((ctrl_m >> 3) & 1) && rc <= 3);
        cmp(segment_switches_out, (1 << (c >> 12)) - 1);
        cmp(ladder_switches_out, c & 'hfff);
        cmp(readback_select_out, rbsel_m);
        cmp(readback_request_out, rbreq_m);
    endtask
    task automatic frame(input logic [31:0] bits, input int n);
        sent_q.push_back(bits[23:0]);
        u_dac_host_model.send(bits, n);
        repeat (8) @(negedge sys_clk_in);
        apply(bits[23:0]);
        cmp(latched_word_out, sent_q.pop_front());
        check_all();
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge sys_clk_in);
        rst_in = 1'b0;
        @(negedge sys_clk_in);
        check_all();
        for (int k = 0; k < 8; k++) begin
            frame(32'h00550000 | (ctrl_m & 'hefff), 24);
            frame(32'h00551000 | k | ((k & 1) << 3), 24);
        end
        $display("test ranges done");
        for (int t = 0; t < 2; t++) begin
            frame(32'h00550000 | (ctrl_m & 'hefff), 24);
            frame(t ? 32'h00551013 : 32'h00551001, 24);
            frame(32'h00010000, 24);
            frame(32'h00018000, 24);
            frame(32'h0001ffff, 24);
            for (int k = 0; k < 4; k++) begin
                r = next_rand();
                frame(32'h00010000 | r[15:0], 24);
            end
        end
        $display("test codes done");
        frame(32'h00020002, 24);
        frame(32'h00000000, 24);
        frame(32'h00010abc, 24);
        frame(32'h00331234, 24);
        frame(32'h00560000, 24);
        frame(32'h00560001, 24);
        $display("test decode done");
        give_verdict();
    end
endmodule
